// ===== loop_ctl_params.svh
`ifndef LOOP_CTL_PARAMS_SVH
`define LOOP_CTL_PARAMS_SVH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_INT_STAT    8'h08
`define OFS_INT_MASK    8'h0C
`define OFS_GOOD_CNT    8'h10
`define OFS_BAD_CNT     8'h14

// control fields
`define CTRL_MOD_EN_BIT 0
`define CTRL_RST        32'h0000_0001
`define INT_MASK_RST    4'h0

// status fields
`define ST_VALID_BIT    0
`define ST_LB_BIT       1
`define ST_POWERED_BIT  2
`define ST_SHARE_BIT    3
`define ST_PEND_BIT     4

// interrupt status fields
`define INT_VRISE_BIT   0
`define INT_VFALL_BIT   1
`define INT_FAIL_BIT    2
`define INT_LBCHG_BIT   3

// responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

// held shared pins after reset: no loop-back, powered down
`define SHARE_RST       2'h1

`endif

// ===== loop_ctl_pkg.sv
`default_nettype none
package loop_ctl_pkg;

  // shared control pins that the bus enable freezes
  typedef struct packed {
    logic power_down_n;
    logic loop_back_n;
  } share_pins_type;

  // outcome of one burst demodulation
  typedef struct packed {
    logic sync_ok;
    logic bit_err;
  } demod_res_type;

  // interrupt event group
  typedef struct packed {
    logic lb_change;
    logic demod_fail;
    logic valid_fall;
    logic valid_rise;
  } int_evt_type;

  // write state of the register slave
  typedef enum logic [1:0] {
    WR_IDLE = 2'b00,
    WR_RESP = 2'b01
  } wr_state_type;

endpackage
`default_nettype wire

// ===== share_pin_latch.sv
`timescale 1ns/1ps
`default_nettype none
`include "loop_ctl_params.svh"

module share_pin_latch
  import loop_ctl_pkg::*;
(
  // clock and reset
  input  wire logic           clk,
  input  wire logic           srst,
  // pins and enable
  input  wire logic           share_en,
  input  wire share_pins_type pin_in,
  // effective levels
  output share_pins_type      pin_eff
);

  share_pins_type held_r;

  // follows the pin while enabled, freezes the last level on the fall
  always_ff @(posedge clk) begin
    if (srst) begin
      held_r <= share_pins_type'(`SHARE_RST);
    end else if (share_en) begin
      held_r <= pin_in; // R13
    end
  end

  assign pin_eff = share_en ? pin_in : held_r; // R3 R10 R13

endmodule // share_pin_latch
`default_nettype wire

// ===== master_loopback_valid_data.sv
// Contract
// R1 - loop-back isolates line input and parks both drivers at reference
// R2 - loop-back feeds own modulator output into own demodulator
// R3 - loop-back level held internally while share enable is low
// R4 - loop-back acts only while powered up
// R5 - valid output high after good demodulation, low otherwise
// R6 - valid means sync found and no bit errors
// R7 - powered up: valid output changes only on frame sync rise
// R8 - powered down: valid output changes when demodulation finishes
// R9 - valid output released to high impedance while share enable low
// R10 - share enable low latches shared inputs and releases shared outputs
// R11 - powered down: no modulation, demodulator keeps running
// R12 - system supplies frame sync; each rise starts one burst
// R13 - loop-back latch transparent while enabled, captures on enable fall
// R14 - in loop-back, valid reports own looped burst with same checks
`timescale 1ns/1ps
`default_nettype none
`include "loop_ctl_params.svh"

module master_loopback_valid_data
  import loop_ctl_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  // line control pins
  input  wire logic        FRAME_SYNC_IN,
  input  wire logic        BUS_SHARE_ENABLE,
  input  wire logic        LOOP_BACK_N,
  input  wire logic        POWER_DOWN_N,
  input  wire logic        DEMOD_RX_PIN,
  // modulator side
  input  wire logic        MOD_BIT,
  input  wire logic        MOD_ACTIVE,
  output logic             MOD_START,
  // demodulator side
  input  wire logic        DEMOD_DONE,
  input  wire logic        DEMOD_SYNC_OK,
  input  wire logic        DEMOD_BIT_ERR,
  output logic             DEMOD_IN,
  // line drivers
  output logic             DRIVE_OUT_POS,
  output logic             DRIVE_OUT_NEG,
  output logic             DRIVE_AT_REF,
  // shared status pin
  output logic             VALID_DATA_OUT,
  output logic             VALID_DATA_OE,
  // interrupt
  output logic             IRQ,
  // axi4-lite write address
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  // axi4-lite write data
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  // axi4-lite write response
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  // axi4-lite read address
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  // axi4-lite read data
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP
);

  // byte-lane merge of a write into a register
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // address belongs to the map
  function automatic logic reg_hit(input logic [7:0] a);
    return (a == `OFS_CTRL) || (a == `OFS_STATUS) || (a == `OFS_INT_STAT) ||
           (a == `OFS_INT_MASK) || (a == `OFS_GOOD_CNT) || (a == `OFS_BAD_CNT);
  endfunction

  // saturating event counter step
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction

  // shared pin freeze
  share_pins_type pins_raw;
  share_pins_type pins_eff;

  assign pins_raw.power_down_n = POWER_DOWN_N;
  assign pins_raw.loop_back_n  = LOOP_BACK_N;

  share_pin_latch u_share (
    .clk      (CLK_SYS),
    .srst     (SRST),
    .share_en (BUS_SHARE_ENABLE),
    .pin_in   (pins_raw),
    .pin_eff  (pins_eff)
  );

  // mode decode
  logic          powered;
  logic          lb_active;
  logic          fs_d_r;
  logic          fs_rise;
  logic [31:0]   ctrl_r;
  logic          mod_en;
  logic          may_modulate;

  assign powered      = pins_eff.power_down_n;
  assign lb_active    = powered & ~pins_eff.loop_back_n; // R3 R4
  assign fs_rise      = FRAME_SYNC_IN & ~fs_d_r;
  assign mod_en       = ctrl_r[`CTRL_MOD_EN_BIT];
  assign may_modulate = powered & mod_en; // R11

  // demodulation judgement
  demod_res_type res;
  logic          res_good;
  logic          pend_r;
  logic          valid_r;
  logic          valid_nxt;
  logic          upd_now;

  assign res.sync_ok = DEMOD_SYNC_OK;
  assign res.bit_err = DEMOD_BIT_ERR;
  assign res_good    = res.sync_ok & ~res.bit_err; // R6 R14

  // powered up: present on frame sync; powered down: on end of burst
  assign upd_now   = powered ? fs_rise : DEMOD_DONE; // R7 R8
  assign valid_nxt = powered ? pend_r : res_good; // R5

  // line path outputs
  logic          demod_in_r;
  logic          pos_r;
  logic          neg_r;
  logic          at_ref_r;
  logic          mod_start_r;
  logic          demod_in_nxt;
  logic          driving;

  // own modulator output replaces the line pin during loop-back
  assign demod_in_nxt = lb_active ? MOD_BIT : DEMOD_RX_PIN; // R1 R2 R11
  assign driving      = may_modulate & ~lb_active & MOD_ACTIVE; // R1 R11

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      fs_d_r      <= 1'b0;
      demod_in_r  <= 1'b0;
      pos_r       <= 1'b0;
      neg_r       <= 1'b0;
      at_ref_r    <= 1'b1;
      mod_start_r <= 1'b0;
    end else begin
      fs_d_r      <= FRAME_SYNC_IN;
      demod_in_r  <= demod_in_nxt; // R2
      pos_r       <= driving & MOD_BIT;
      neg_r       <= driving & ~MOD_BIT;
      at_ref_r    <= ~driving; // R1
      mod_start_r <= fs_rise & may_modulate; // R12 R11
    end
  end

  // valid flag and its shared pin
  logic          vd_out_r;
  logic          vd_oe_r;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      pend_r   <= 1'b0;
      valid_r  <= 1'b0;
      vd_out_r <= 1'b0;
      vd_oe_r  <= 1'b0;
    end else begin
      if (DEMOD_DONE) begin
        pend_r <= res_good; // R6 R14
      end else if (powered && fs_rise) begin
        pend_r <= 1'b0;
      end
      if (upd_now) begin
        valid_r <= valid_nxt; // R5 R7 R8
      end
      vd_out_r <= BUS_SHARE_ENABLE & (upd_now ? valid_nxt : valid_r);
      vd_oe_r  <= BUS_SHARE_ENABLE; // R9 R10
    end
  end

  // events and counters
  int_evt_type   evt;
  logic          lb_d_r;
  logic [15:0]   good_cnt_r;
  logic [15:0]   bad_cnt_r;
  logic [3:0]    int_stat_r;
  logic [3:0]    int_stat_nxt;
  logic [3:0]    int_mask_r;
  logic [3:0]    int_clr;
  logic          irq_r;

  assign evt.valid_rise = upd_now & valid_nxt & ~valid_r;
  assign evt.valid_fall = upd_now & ~valid_nxt & valid_r;
  assign evt.demod_fail = DEMOD_DONE & ~res_good;
  assign evt.lb_change  = lb_active ^ lb_d_r;

  // a new event wins over a clear in the same cycle
  assign int_stat_nxt = (int_stat_r & ~int_clr) | evt;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      lb_d_r     <= 1'b0;
      good_cnt_r <= 16'h0000;
      bad_cnt_r  <= 16'h0000;
      int_stat_r <= 4'h0;
      irq_r      <= 1'b0;
    end else begin
      lb_d_r     <= lb_active;
      int_stat_r <= int_stat_nxt;
      irq_r      <= |(int_stat_nxt & int_mask_r);
      if (DEMOD_DONE && res_good) begin
        good_cnt_r <= sat_inc(good_cnt_r);
      end
      if (DEMOD_DONE && !res_good) begin
        bad_cnt_r <= sat_inc(bad_cnt_r);
      end
    end
  end

  // register slave: write side
  wr_state_type  wr_st_r;
  logic          awready_r;
  logic          wready_r;
  logic [7:0]    aw_addr_r;
  logic [31:0]   w_data_r;
  logic [3:0]    w_strb_r;
  logic [1:0]    bresp_r;
  logic          wr_fire;
  logic          wr_hit;
  logic [31:0]   ctrl_wr;
  logic [31:0]   mask_wr;
  logic [31:0]   clr_wr;

  assign wr_fire = (wr_st_r == WR_IDLE) & ~awready_r & ~wready_r;
  assign wr_hit  = reg_hit(aw_addr_r);
  assign ctrl_wr = merge_strb(ctrl_r, w_data_r, w_strb_r);
  assign mask_wr = merge_strb({28'h0, int_mask_r}, w_data_r, w_strb_r);
  assign clr_wr  = merge_strb(32'h0, w_data_r, w_strb_r);
  assign int_clr = (wr_fire && aw_addr_r == `OFS_INT_STAT) ? clr_wr[3:0] : 4'h0;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      wr_st_r    <= WR_IDLE;
      awready_r  <= 1'b1;
      wready_r   <= 1'b1;
      aw_addr_r  <= 8'h00;
      w_data_r   <= 32'h0000_0000;
      w_strb_r   <= 4'h0;
      bresp_r    <= `RESP_OKAY;
      ctrl_r     <= `CTRL_RST;
      int_mask_r <= `INT_MASK_RST;
    end else begin
      if (AWVALID && awready_r) begin
        awready_r <= 1'b0;
        aw_addr_r <= AWADDR;
      end
      if (WVALID && wready_r) begin
        wready_r <= 1'b0;
        w_data_r <= WDATA;
        w_strb_r <= WSTRB;
      end
      unique case (wr_st_r)
        WR_IDLE: begin
          if (wr_fire) begin
            wr_st_r <= WR_RESP;
            bresp_r <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            if (aw_addr_r == `OFS_CTRL) begin
              ctrl_r <= {31'h0, ctrl_wr[`CTRL_MOD_EN_BIT]};
            end
            if (aw_addr_r == `OFS_INT_MASK) begin
              int_mask_r <= mask_wr[3:0];
            end
          end
        end
        WR_RESP: begin
          if (BREADY) begin
            wr_st_r   <= WR_IDLE;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
          end
        end
      endcase
    end
  end

  // register slave: read side
  logic          arready_r;
  logic          rvalid_r;
  logic [31:0]   rdata_r;
  logic [1:0]    rresp_r;
  logic [31:0]   status_v;
  logic [31:0]   rd_mux;

  assign status_v = {27'h0, pend_r, BUS_SHARE_ENABLE, powered, lb_active, valid_r};
  assign rd_mux   = (ARADDR == `OFS_CTRL)     ? ctrl_r :
                    (ARADDR == `OFS_STATUS)   ? status_v :
                    (ARADDR == `OFS_INT_STAT) ? {28'h0, int_stat_r} :
                    (ARADDR == `OFS_INT_MASK) ? {28'h0, int_mask_r} :
                    (ARADDR == `OFS_GOOD_CNT) ? {16'h0, good_cnt_r} :
                    (ARADDR == `OFS_BAD_CNT)  ? {16'h0, bad_cnt_r} :
                    32'h0000_0000;

  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `RESP_OKAY;
    end else if (ARVALID && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_mux;
      rresp_r   <= reg_hit(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && RREADY) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // output drive
  assign MOD_START      = mod_start_r;
  assign DEMOD_IN       = demod_in_r;
  assign DRIVE_OUT_POS  = pos_r;
  assign DRIVE_OUT_NEG  = neg_r;
  assign DRIVE_AT_REF   = at_ref_r;
  assign VALID_DATA_OUT = vd_out_r;
  assign VALID_DATA_OE  = vd_oe_r;
  assign IRQ            = irq_r;
  assign AWREADY        = awready_r;
  assign WREADY         = wready_r;
  assign BVALID         = wr_st_r[0];
  assign BRESP          = bresp_r;
  assign ARREADY        = arready_r;
  assign RVALID         = rvalid_r;
  assign RDATA          = rdata_r;
  assign RRESP          = rresp_r;

endmodule // master_loopback_valid_data
`default_nettype wire

// ===== slave_link_model.sv
`timescale 1ns/1ps
`default_nettype none

module slave_link_model
  import loop_ctl_pkg::*;
(
  // clock and reset
  input  wire logic          clk,
  input  wire logic          srst,
  // burst order from bench
  input  wire logic          go,
  input  wire demod_res_type res,
  // demodulator side
  input  wire logic          mod_start,
  output logic               demod_done,
  output logic               sync_ok,
  output logic               bit_err,
  output logic               mod_active
);
  logic [2:0] wait_r;
  logic [2:0] act_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      wait_r     <= 3'h0;
      act_r      <= 3'h0;
      demod_done <= 1'b0;
      sync_ok    <= 1'b0;
      bit_err    <= 1'b1;
      mod_active <= 1'b0;
    end else begin
      wait_r     <= go ? 3'h4 : (wait_r != 3'h0 ? wait_r - 3'h1 : 3'h0);
      demod_done <= (wait_r == 3'h1);
      // qualifiers toggle outside the done pulse
      sync_ok    <= (wait_r == 3'h1) ? res.sync_ok : ~sync_ok;
      bit_err    <= (wait_r == 3'h1) ? res.bit_err : ~bit_err;
      act_r      <= mod_start ? 3'h4 : (act_r != 3'h0 ? act_r - 3'h1 : 3'h0);
      mod_active <= (act_r != 3'h0);
    end
  end
endmodule // slave_link_model
`default_nettype wire

// ===== loop_ctl_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module loop_ctl_monitor (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SRST,
  // pins
  input wire logic FRAME_SYNC_IN,
  input wire logic BUS_SHARE_ENABLE,
  input wire logic LOOP_BACK_N,
  input wire logic POWER_DOWN_N,
  input wire logic DEMOD_RX_PIN,
  input wire logic MOD_BIT,
  // datapath
  input wire logic MOD_START,
  input wire logic DEMOD_DONE,
  input wire logic DEMOD_SYNC_OK,
  input wire logic DEMOD_BIT_ERR,
  input wire logic DEMOD_IN,
  input wire logic DRIVE_OUT_POS,
  input wire logic DRIVE_OUT_NEG,
  input wire logic DRIVE_AT_REF,
  input wire logic VALID_DATA_OUT,
  input wire logic VALID_DATA_OE
);
  logic res_r;
  logic fs_d_r;
  wire  fs_rise = FRAME_SYNC_IN && !fs_d_r;
  wire  lb_on   = BUS_SHARE_ENABLE && !LOOP_BACK_N && POWER_DOWN_N;

  // last burst result since the previous frame
  always_ff @(posedge CLK_SYS) begin
    if (SRST) begin
      res_r  <= 1'b0;
      fs_d_r <= 1'b0;
    end else begin
      fs_d_r <= FRAME_SYNC_IN;
      if (DEMOD_DONE)
        res_r <= DEMOD_SYNC_OK && !DEMOD_BIT_ERR;
      else if (fs_rise && POWER_DOWN_N)
        res_r <= 1'b0;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SRST);

  drivers_ref_a: assert property (
    lb_on |=> DRIVE_AT_REF && !DRIVE_OUT_POS && !DRIVE_OUT_NEG)
    else $error("drivers not parked in loop-back");
  loop_feed_a: assert property (lb_on |=> DEMOD_IN == $past(MOD_BIT))
    else $error("demod input not looped");
  line_feed_a: assert property (
    BUS_SHARE_ENABLE && LOOP_BACK_N |=> DEMOD_IN == $past(DEMOD_RX_PIN))
    else $error("demod input not from line");
  pd_ignore_a: assert property (
    BUS_SHARE_ENABLE && !POWER_DOWN_N |=> DRIVE_AT_REF && DEMOD_IN == $past(DEMOD_RX_PIN))
    else $error("loop-back acts in power-down");
  latch_hold_a: assert property (lb_on ##1 !BUS_SHARE_ENABLE [*2] |=> DRIVE_AT_REF)
    else $error("held loop-back lost");
  vd_release_a: assert property (!BUS_SHARE_ENABLE |=> !VALID_DATA_OE && !VALID_DATA_OUT)
    else $error("valid pin driven while disabled");
  vd_frame_a: assert property (
    fs_rise && POWER_DOWN_N && BUS_SHARE_ENABLE |=> VALID_DATA_OUT == $past(res_r))
    else $error("valid wrong after frame");
  vd_steady_a: assert property (
    POWER_DOWN_N && $past(POWER_DOWN_N) && BUS_SHARE_ENABLE && $past(BUS_SHARE_ENABLE)
    && !fs_rise |=> $stable(VALID_DATA_OUT))
    else $error("valid changed between frames");
  vd_done_a: assert property (
    DEMOD_DONE && !POWER_DOWN_N && BUS_SHARE_ENABLE
    |=> VALID_DATA_OUT == $past(DEMOD_SYNC_OK && !DEMOD_BIT_ERR))
    else $error("valid wrong after powered-down burst");
  mod_off_a: assert property ((BUS_SHARE_ENABLE && !POWER_DOWN_N) [*3] |-> !MOD_START)
    else $error("burst started in power-down");

  cover property (fs_rise && res_r && POWER_DOWN_N);
  cover property (DEMOD_DONE && !POWER_DOWN_N);
  cover property (lb_on ##1 !BUS_SHARE_ENABLE);
endmodule // loop_ctl_monitor

bind master_loopback_valid_data loop_ctl_monitor loop_ctl_monitor_inst (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .FRAME_SYNC_IN(FRAME_SYNC_IN),
  .BUS_SHARE_ENABLE(BUS_SHARE_ENABLE), .LOOP_BACK_N(LOOP_BACK_N),
  .POWER_DOWN_N(POWER_DOWN_N), .DEMOD_RX_PIN(DEMOD_RX_PIN), .MOD_BIT(MOD_BIT),
  .MOD_START(MOD_START), .DEMOD_DONE(DEMOD_DONE), .DEMOD_SYNC_OK(DEMOD_SYNC_OK),
  .DEMOD_BIT_ERR(DEMOD_BIT_ERR), .DEMOD_IN(DEMOD_IN), .DRIVE_OUT_POS(DRIVE_OUT_POS),
  .DRIVE_OUT_NEG(DRIVE_OUT_NEG), .DRIVE_AT_REF(DRIVE_AT_REF),
  .VALID_DATA_OUT(VALID_DATA_OUT), .VALID_DATA_OE(VALID_DATA_OE));
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "loop_ctl_params.svh"

module testbench
  import loop_ctl_pkg::*;
;
  logic CLK_SYS = 0, SRST = 1, FRAME_SYNC_IN = 0, BUS_SHARE_ENABLE = 1, LOOP_BACK_N = 1;
  logic POWER_DOWN_N = 1, DEMOD_RX_PIN = 0, MOD_BIT = 0, MOD_ACTIVE, MOD_START, DEMOD_DONE;
  logic DEMOD_SYNC_OK, DEMOD_BIT_ERR, DEMOD_IN, DRIVE_OUT_POS, DRIVE_OUT_NEG, DRIVE_AT_REF;
  logic VALID_DATA_OUT, VALID_DATA_OE, IRQ, AWVALID = 0, AWREADY, WVALID = 0, WREADY;
  logic BVALID, BREADY = 0, ARVALID = 0, ARREADY, RVALID, RREADY = 0, go = 0;
  logic [7:0]    AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0]   WDATA = 32'h0, RDATA, rnd = 32'h4111;
  logic [3:0]    WSTRB = 4'hF;
  logic [1:0]    BRESP, RRESP;
  logic [65:0]   exp_q[$];
  logic [65:0]   note;
  demod_res_type res = 2'h0;
  int            num_errors = 0, samples_checked = 0, cycles = 0;

  master_loopback_valid_data master_loopback_valid_data_inst (
    .CLK_SYS(CLK_SYS), .SRST(SRST), .FRAME_SYNC_IN(FRAME_SYNC_IN),
    .BUS_SHARE_ENABLE(BUS_SHARE_ENABLE), .LOOP_BACK_N(LOOP_BACK_N),
    .POWER_DOWN_N(POWER_DOWN_N), .DEMOD_RX_PIN(DEMOD_RX_PIN), .MOD_BIT(MOD_BIT),
    .MOD_ACTIVE(MOD_ACTIVE), .MOD_START(MOD_START), .DEMOD_DONE(DEMOD_DONE),
    .DEMOD_SYNC_OK(DEMOD_SYNC_OK), .DEMOD_BIT_ERR(DEMOD_BIT_ERR), .DEMOD_IN(DEMOD_IN),
    .DRIVE_OUT_POS(DRIVE_OUT_POS), .DRIVE_OUT_NEG(DRIVE_OUT_NEG),
    .DRIVE_AT_REF(DRIVE_AT_REF), .VALID_DATA_OUT(VALID_DATA_OUT),
    .VALID_DATA_OE(VALID_DATA_OE), .IRQ(IRQ), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .AWADDR(AWADDR), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY),
    .RDATA(RDATA), .RRESP(RRESP));
  slave_link_model slave_link_model_inst (.clk(CLK_SYS), .srst(SRST), .go(go), .res(res),
    .mod_start(MOD_START), .demod_done(DEMOD_DONE), .sync_ok(DEMOD_SYNC_OK),
    .bit_err(DEMOD_BIT_ERR), .mod_active(MOD_ACTIVE));

  always #4 CLK_SYS = ~CLK_SYS;

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // random line and modulator symbols, cycle ceiling
  always @(posedge CLK_SYS) begin
    rnd <= xs(rnd);
    DEMOD_RX_PIN <= rnd[0];
    MOD_BIT <= rnd[1];
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  // read results against the oldest note
  always @(posedge CLK_SYS) begin
    if (RVALID === 1'b1 && RREADY) begin
      note = exp_q.pop_front();
      chk("rdata", note[33:2], RDATA & note[65:34]);
      chk("rresp", note[1:0], RRESP);
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w;
    aw = 0;
    w = 0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1;
    WVALID <= 1;
    BREADY <= 1;
    while (!(aw && w)) begin
      @(posedge CLK_SYS);
      if (AWREADY === 1'b1 && !aw) begin
        aw = 1;
        AWVALID <= 0;
      end
      if (WREADY === 1'b1 && !w) begin
        w = 1;
        WVALID <= 0;
      end
    end
    do @(posedge CLK_SYS); while (BVALID !== 1'b1);
    BREADY <= 0;
    chk("bresp", {30'h0, r}, {30'h0, BRESP});
    @(posedge CLK_SYS);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic [1:0] r);
    exp_q.push_back({m, e, r});
    ARADDR <= a;
    ARVALID <= 1;
    RREADY <= 1;
    do @(posedge CLK_SYS); while (ARREADY !== 1'b1);
    ARVALID <= 0;
    do @(posedge CLK_SYS); while (RVALID !== 1'b1);
    RREADY <= 0;
    @(posedge CLK_SYS);
  endtask

  task automatic burst(input demod_res_type v);
    res <= v;
    go <= 1;
    @(posedge CLK_SYS);
    go <= 0;
    repeat (8) @(posedge CLK_SYS);
  endtask

  task automatic frame;
    FRAME_SYNC_IN <= 1;
    repeat (3) @(posedge CLK_SYS);
    FRAME_SYNC_IN <= 0;
    repeat (3) @(posedge CLK_SYS);
  endtask

  initial begin
    repeat (2) @(posedge CLK_SYS);
    SRST <= 0;
    @(posedge CLK_SYS);
    rd(`OFS_CTRL, `CTRL_RST, 32'hFFFFFFFF, `RESP_OKAY);
    rd(`OFS_INT_MASK, 32'h0, 32'hF, `RESP_OKAY);
    rd(8'h18, 32'h0, 32'hFFFFFFFF, `RESP_SLVERR);
    wr(8'h1C, 32'h1, `RESP_SLVERR);
    wr(`OFS_INT_STAT, 32'hF, `RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      burst(i[1:0]);
      frame();
      rd(`OFS_STATUS, {28'h0, 3'h6, i == 2}, 32'hF, `RESP_OKAY);
      chk("vd", {31'h0, i == 2}, {31'h0, VALID_DATA_OUT});
    end
    rd(`OFS_GOOD_CNT, 32'h1, 32'hFFFF, `RESP_OKAY);
    rd(`OFS_BAD_CNT, 32'h3, 32'hFFFF, `RESP_OKAY);
    rd(`OFS_INT_STAT, 32'h7, 32'h7, `RESP_OKAY);
    wr(`OFS_INT_MASK, 32'h4, `RESP_OKAY);
    repeat (2) @(posedge CLK_SYS);
    chk("irq", 32'h1, {31'h0, IRQ});
    wr(`OFS_INT_STAT, 32'h4, `RESP_OKAY);
    repeat (2) @(posedge CLK_SYS);
    chk("irq", 32'h0, {31'h0, IRQ});
    LOOP_BACK_N <= 0;
    repeat (3) @(posedge CLK_SYS);
    rd(`OFS_STATUS, 32'h2, 32'h2, `RESP_OKAY);
    rd(`OFS_INT_STAT, 32'h8, 32'h8, `RESP_OKAY);
    burst(2'h2);
    frame();
    rd(`OFS_STATUS, 32'h1, 32'h1, `RESP_OKAY);
    BUS_SHARE_ENABLE <= 0;
    repeat (2) @(posedge CLK_SYS);
    LOOP_BACK_N <= 1;
    repeat (3) @(posedge CLK_SYS);
    chk("oe", 32'h0, {31'h0, VALID_DATA_OE});
    rd(`OFS_STATUS, 32'h2, 32'hA, `RESP_OKAY);
    BUS_SHARE_ENABLE <= 1;
    repeat (3) @(posedge CLK_SYS);
    rd(`OFS_STATUS, 32'h8, 32'hA, `RESP_OKAY);
    LOOP_BACK_N <= 0;
    POWER_DOWN_N <= 0;
    repeat (3) @(posedge CLK_SYS);
    burst(2'h3);
    rd(`OFS_STATUS, 32'h0, 32'h7, `RESP_OKAY);
    burst(2'h2);
    rd(`OFS_STATUS, 32'h1, 32'h7, `RESP_OKAY);
    conclude();
  end
endmodule // testbench
`default_nettype wire
